// ===== rtl/cse_consts.vh
/*
  Constants for the stop and error handler: register offsets, reset
  values, stop codes, storage limits and sequence state codes.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef CSE_CONSTS_VH
`define CSE_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSE_OFF_CTRL 12'h000
`define CSE_OFF_MAXLEN 12'h004
`define CSE_OFF_STATUS 12'h008
`define CSE_OFF_HOLD 12'h00c
`define CSE_OFF_ADDR 12'h010
`define CSE_OFF_NEXTIA 12'h014

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSE_CTRL_RST 8'hf2
`define CSE_MAXLEN_RST 32'hff505050

// ----------------------------------------
// stop codes
// ----------------------------------------
`define CSE_CODE_NONE 4'h0
`define CSE_CODE_INVOP 4'h1
`define CSE_CODE_ADLO 4'h4
`define CSE_CODE_ADHI 4'h5
`define CSE_CODE_SPEC 4'h6
`define CSE_ATTN_MARK 4'hf

// ----------------------------------------
// storage limits, field limits and checked opcodes
// ----------------------------------------
`define CSE_PROT_BOUND 16'h0090
`define CSE_TOP_4K 16'h0fff
`define CSE_TOP_8K 16'h1fff
`define CSE_TOP_16K 16'h3fff
`define CSE_LEN_MUL_MAX 4'h7
`define CSE_OP_BC_REG 8'h07
`define CSE_OP_BAS_REG 8'h0d
`define CSE_OP_BC_RX 8'h47
`define CSE_OP_XFER 8'hd0
`define CSE_OP_EDIT 8'hde
`define CSE_OP_DADD 8'hfa
`define CSE_OP_DSUB 8'hfb
`define CSE_OP_DMUL 8'hfc
`define CSE_OP_DCMP 8'hfd

// ----------------------------------------
// stop sequence states
// ----------------------------------------
`define CSE_ST_IDLE 4'h0
`define CSE_ST_PARK 4'h1
`define CSE_ST_MARK 4'h2
`define CSE_ST_XCH1 4'h3
`define CSE_ST_RECALL 4'h4
`define CSE_ST_SAVE 4'h5
`define CSE_ST_XCH2 4'h6
`define CSE_ST_RESTORE 4'h7
`define CSE_ST_PCOPY 4'h8
`define CSE_ST_XCH3 4'h9
`define CSE_ST_FETCH 4'ha
`define CSE_ST_HALT 4'hb

`endif

// ===== rtl/cse_stop_error_handler.v
/*
  Program error and I/O attention stop handler with an AHB-Lite register
  slave. Checks each instruction decoded while the run latch is set and
  the stop sequence is idle, loads the stop holders through a fixed
  sequence and clears the run latch.
  Assumes decode/execute and storage on hclk; unit and console pins are
  asynchronous and pass through cse_sync.
*/
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cse_consts.vh"

module cse_stop_error_handler (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // decode and execute
  input wire dec_valid,
  input wire [7:0] dec_opcode,
  input wire [15:0] dec_ia,
  input wire dec_oa_valid,
  input wire [15:0] dec_oa,
  input wire [3:0] first_register_field,
  input wire [3:0] second_register_field,
  input wire [3:0] first_length_field,
  input wire [3:0] second_length_field,
  input wire dec_io,
  input wire [1:0] dec_unit,
  input wire [7:0] dec_len,
  input wire dec_edit_bad,
  input wire dec_test,
  // storage read for opcode refetch
  output reg mem_req,
  output reg [15:0] mem_addr,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  // unit and console pins
  input wire [3:0] unit_not_ready,
  input wire [3:0] unit_feed_chk,
  input wire [3:0] unit_chk,
  input wire start_key,
  input wire chk_reset_key,
  input wire sys_reset_key,
  // run control
  output reg run_latch,
  output reg stop_ind,
  output reg [15:0] resume_ia
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [14:0] pins_s;
  cse_sync #(.W(15)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({sys_reset_key, chk_reset_key, start_key, unit_chk, unit_feed_chk, unit_not_ready}),
    .sync_out(pins_s)
  );
  wire [3:0] nrdy_s = pins_s[3:0];
  wire [3:0] feed_s = pins_s[7:4];
  wire [3:0] chk_s = pins_s[11:8];
  wire start_s = pins_s[12];
  wire chkrst_s = pins_s[13];
  wire sysrst_s = pins_s[14];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] ctrl_reg;
  reg [31:0] maxlen_reg;
  reg [3:0] stop_code_holder, attention_holder;
  reg [3:0] opcode_high_holder, opcode_low_holder;
  reg [3:0] addr_top_holder, addr_upper_holder;
  reg [3:0] middle_address_holder, low_address_holder;
  reg [11:0] shadow_reg;
  reg [15:0] recall_reg;
  reg [3:0] state_reg;
  reg attn_reg, start_d_reg;
  reg [3:0] chk_prev_reg, chk_lat_reg;

  // ----------------------------------------
  // valid opcode set
  // ----------------------------------------
  function op_ok;
    input [7:0] op;
    begin
      case (op)
        8'h07, 8'h0d, 8'h18, 8'h19, 8'h1a, 8'h1b,
        8'h40, 8'h41, 8'h42, 8'h43, 8'h45, 8'h47,
        8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
        8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h97,
        8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e,
        8'h9f, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4,
        8'hd5, 8'hd6, 8'hd7, 8'hdc, 8'hde, 8'hfa,
        8'hfb, 8'hfc, 8'hfd: op_ok = 1'b1;
        default: op_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // instruction checks
  // ----------------------------------------
  reg [15:0] top_addr;
  always @* begin
    case (ctrl_reg[1:0])
      2'd0: top_addr = `CSE_TOP_4K;
      2'd1: top_addr = `CSE_TOP_8K;
      default: top_addr = `CSE_TOP_16K;
    endcase
  end

  wire is_regreg = (dec_opcode[7:6] == 2'b00);
  wire is_rx = (dec_opcode[7:6] == 2'b01);
  wire is_half = (dec_opcode == 8'h40) || (dec_opcode >= 8'h48 && dec_opcode <= 8'h4d);
  wire [7:0] unit_max = maxlen_reg[{dec_unit, 3'b000} +: 8];
  wire attached = ctrl_reg[4 + dec_unit];
  // not-ready, feed check and latched check block the unit
  wire unit_busy = nrdy_s[dec_unit] | feed_s[dec_unit] | chk_lat_reg[dec_unit];

  wire err_lo = (dec_ia < `CSE_PROT_BOUND) || (dec_oa_valid && dec_oa < `CSE_PROT_BOUND);
  wire err_hi = (dec_ia > top_addr) || (dec_oa_valid && dec_oa > top_addr);
  wire err_reg = (is_regreg && dec_opcode != `CSE_OP_BC_REG && (!first_register_field[3] ||
                 (dec_opcode != `CSE_OP_BAS_REG && !second_register_field[3]))) ||
                 (is_rx && dec_opcode != `CSE_OP_BC_RX && !first_register_field[3]);

  reg err_spec;
  always @* begin
    err_spec = 1'b0;
    if (dec_ia[0])
      err_spec = 1'b1;
    if (is_rx && is_half && dec_oa_valid && dec_oa[0])
      err_spec = 1'b1;
    if (is_rx && second_register_field != 4'h0)
      err_spec = 1'b1;
    if ((dec_opcode == `CSE_OP_DADD || dec_opcode == `CSE_OP_DSUB || dec_opcode == `CSE_OP_DCMP) &&
        second_length_field > first_length_field)
      err_spec = 1'b1;
    if (dec_opcode == `CSE_OP_DMUL &&
        (second_length_field > `CSE_LEN_MUL_MAX || second_length_field >= first_length_field))
      err_spec = 1'b1;
    if (dec_io && !attached)
      err_spec = 1'b1;
    if (dec_opcode == `CSE_OP_XFER && (dec_len == 8'h00 || dec_len > unit_max))
      err_spec = 1'b1;
    if (dec_opcode == `CSE_OP_EDIT && dec_edit_bad)
      err_spec = 1'b1;
  end

  reg [3:0] err_code;
  always @* begin
    if (!op_ok(dec_opcode))
      err_code = `CSE_CODE_INVOP;
    else if (err_lo)
      err_code = `CSE_CODE_ADLO;
    else if (err_hi || err_reg)
      err_code = `CSE_CODE_ADHI;
    else if (err_spec)
      err_code = `CSE_CODE_SPEC;
    else
      err_code = `CSE_CODE_NONE;
  end

  wire take = dec_valid && run_latch && state_reg == `CSE_ST_IDLE;
  wire prog_err = take && err_code != `CSE_CODE_NONE;
  // attention only for an otherwise clean I/O instruction
  wire attn_err = take && err_code == `CSE_CODE_NONE && dec_io && unit_busy;

  // ----------------------------------------
  // check condition latches
  // ----------------------------------------
  reg [3:0] test_clr;
  always @* begin
    test_clr = 4'h0;
    if (dec_valid && dec_test)
      test_clr[dec_unit] = 1'b1;
  end

  // set on a new check, cleared by a program test
  // reset key clears these, feed checks stay with the unit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_prev_reg <= 4'h0;
      chk_lat_reg <= 4'h0;
    end else begin
      chk_prev_reg <= chk_s;
      chk_lat_reg <= (chk_lat_reg & ~(test_clr | {4{chkrst_s | sysrst_s}})) | (chk_s & ~chk_prev_reg);
    end
  end

  // ----------------------------------------
  // stop sequence and holders
  // ----------------------------------------
  wire [15:0] estr = {addr_top_holder, addr_upper_holder, middle_address_holder, low_address_holder};
  wire [11:0] str = estr[11:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= `CSE_ST_IDLE;
      attn_reg <= 1'b0;
      run_latch <= 1'b0;
      stop_ind <= 1'b1;
      start_d_reg <= 1'b0;
      stop_code_holder <= 4'h0;
      attention_holder <= 4'h0;
      opcode_high_holder <= 4'h0;
      opcode_low_holder <= 4'h0;
      addr_top_holder <= 4'h0;
      addr_upper_holder <= 4'h0;
      middle_address_holder <= 4'h0;
      low_address_holder <= 4'h0;
      shadow_reg <= 12'h000;
      recall_reg <= 16'h0000;
      resume_ia <= 16'h0000;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
    end else if (sysrst_s) begin
      state_reg <= `CSE_ST_IDLE;
      attn_reg <= 1'b0;
      run_latch <= 1'b0;
      stop_ind <= 1'b1;
      start_d_reg <= start_s;
      stop_code_holder <= 4'h0;
      attention_holder <= 4'h0;
      opcode_high_holder <= 4'h0;
      opcode_low_holder <= 4'h0;
      addr_top_holder <= 4'h0;
      addr_upper_holder <= 4'h0;
      middle_address_holder <= 4'h0;
      low_address_holder <= 4'h0;
      shadow_reg <= 12'h000;
      resume_ia <= 16'h0000;
      mem_req <= 1'b0;
    end else begin
      start_d_reg <= start_s;
      case (state_reg)
        `CSE_ST_IDLE: begin
          // start resumes at the held address
          if (!run_latch && start_s && !start_d_reg) begin
            run_latch <= 1'b1;
            stop_ind <= 1'b0;
          end
          // only this instruction stops, no abort is issued
          if (prog_err || attn_err) begin
            attn_reg <= attn_err;
            recall_reg <= dec_ia;
            if (prog_err)
              stop_code_holder <= err_code;
            state_reg <= `CSE_ST_PARK;
          end
        end
        `CSE_ST_PARK: begin
          // park the error code in the low holder
          low_address_holder <= attn_reg ? 4'h0 : stop_code_holder;
          state_reg <= `CSE_ST_MARK;
        end
        `CSE_ST_MARK: begin
          middle_address_holder <= attn_reg ? `CSE_ATTN_MARK : 4'h0;
          state_reg <= `CSE_ST_XCH1;
        end
        `CSE_ST_XCH1, `CSE_ST_XCH2, `CSE_ST_XCH3: begin
          shadow_reg <= str;
          {addr_upper_holder, middle_address_holder, low_address_holder} <= shadow_reg;
          state_reg <= state_reg + 4'h1;
        end
        `CSE_ST_RECALL: begin
          {addr_top_holder, addr_upper_holder, middle_address_holder, low_address_holder} <= recall_reg;
          state_reg <= `CSE_ST_SAVE;
        end
        `CSE_ST_SAVE: begin
          resume_ia <= estr;
          state_reg <= `CSE_ST_XCH2;
        end
        `CSE_ST_RESTORE: begin
          stop_code_holder <= low_address_holder;
          state_reg <= `CSE_ST_PCOPY;
        end
        `CSE_ST_PCOPY: begin
          attention_holder <= middle_address_holder;
          state_reg <= `CSE_ST_XCH3;
        end
        `CSE_ST_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= estr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            opcode_high_holder <= mem_rdata[7:4];
            opcode_low_holder <= mem_rdata[3:0];
            state_reg <= `CSE_ST_HALT;
          end
        end
        `CSE_ST_HALT: begin
          run_latch <= 1'b0;
          stop_ind <= 1'b1;
          state_reg <= `CSE_ST_IDLE;
        end
        default: state_reg <= `CSE_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // ahb-lite register slave
  // ----------------------------------------
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  wire addr_ph = hsel && hready && htrans[1];

  reg [31:0] rd_mux;
  always @* begin
    case (haddr)
      `CSE_OFF_CTRL: rd_mux = {24'h000000, ctrl_reg};
      `CSE_OFF_MAXLEN: rd_mux = maxlen_reg;
      `CSE_OFF_STATUS: rd_mux = {16'h0000, chk_lat_reg, state_reg, 5'h00, attn_reg,
                                 stop_ind, run_latch};
      `CSE_OFF_HOLD: rd_mux = {16'h0000, attention_holder, stop_code_holder,
                               opcode_high_holder, opcode_low_holder};
      `CSE_OFF_ADDR: rd_mux = {16'h0000, estr};
      `CSE_OFF_NEXTIA: rd_mux = {16'h0000, resume_ia};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      ctrl_reg <= `CSE_CTRL_RST;
      maxlen_reg <= `CSE_MAXLEN_RST;
    end else begin
      wr_pend_reg <= addr_ph && hwrite;
      if (addr_ph)
        wr_addr_reg <= haddr;
      hrdata <= (addr_ph && !hwrite) ? rd_mux : 32'h00000000;
      if (wr_pend_reg && wr_addr_reg == `CSE_OFF_CTRL)
        ctrl_reg <= hwdata[7:0];
      if (wr_pend_reg && wr_addr_reg == `CSE_OFF_MAXLEN)
        maxlen_reg <= hwdata;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cse_sync.v
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes the inputs are quasi-static levels from unit or console pins.
*/
`timescale 1ns/1ps
`default_nettype none

module cse_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cse_seh_props.sv
/*
  Port checker for the stop handler.
  Assumes binding to the design top; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module cse_seh_props (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // observed ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dec_valid,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic run_latch,
  input wire logic stop_ind,
  input wire logic [15:0] resume_ia,
  input wire logic sys_reset_key
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // stop sequence steps
  // ----------------------------------------
  sequence acked_s;
    mem_req && mem_ack;
  endsequence
  sequence halt_s;
    !mem_req && run_latch ##1 !run_latch && stop_ind;
  endsequence
  stop_lamp_a: assert property (stop_ind == !run_latch)
    else $error("stop lamp differs from run latch");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  fetch_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("refetch request dropped early");
  halt_after_a: assert property (acked_s |=> halt_s)
    else $error("run latch not cleared after refetch");
  fetch_addr_a: assert property (mem_req |-> mem_addr == resume_ia)
    else $error("refetch address differs from resume address");
  seq_len_a: assert property ($rose(mem_req) |-> $past(dec_valid, 10) || $past(dec_valid, 11))
    else $error("refetch not ten cycles after decode");
  one_stop_a: assert property (!run_latch |=> !$rose(mem_req))
    else $error("second stop sequence while stopped");
  resume_keep_a: assert property (disable iff (!hresetn || sys_reset_key)
    !run_latch && !$past(run_latch) |-> $stable(resume_ia))
    else $error("resume address changed while stopped");
endmodule
bind cse_stop_error_handler cse_seh_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .dec_valid(dec_valid),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .run_latch(run_latch),
  .stop_ind(stop_ind), .resume_ia(resume_ia), .sys_reset_key(sys_reset_key)
);
`default_nettype wire

// ===== tb/cse_unit_model.sv
/*
  Far-side model: card and print unit levels plus the storage read port.
  Assumes the bench steers unit conditions through the cmd inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module cse_unit_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench steering
  input wire logic [3:0] nr_cmd,
  input wire logic [3:0] feed_cmd,
  input wire logic [3:0] chk_cmd,
  input wire logic [3:0] mem_lat,
  input wire logic [7:0] op_byte,
  // unit pins
  output logic [3:0] unit_not_ready,
  output logic [3:0] unit_feed_chk,
  output logic [3:0] unit_chk,
  // storage read
  input wire logic mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [2:0] pwr_cnt;
  logic [3:0] wait_cnt;
  logic take;
  assign take = mem_req && !mem_ack && wait_cnt == mem_lat;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_cnt <= 3'h0;
      unit_not_ready <= 4'hf;
      unit_feed_chk <= 4'h0;
      unit_chk <= 4'h0;
    end else begin
      if (pwr_cnt != 3'h7) pwr_cnt <= pwr_cnt + 3'h1;
      unit_not_ready <= nr_cmd | {4{pwr_cnt != 3'h7}};
      unit_feed_chk <= feed_cmd;
      unit_chk <= chk_cmd;
    end
  end
  // data line toggles when not answering
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= take;
      wait_cnt <= (mem_req && !mem_ack && !take) ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= take ? op_byte : ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_cpu_stop_error_handler.sv
/*
  Bench for the stop handler: bus tasks, decode runs and unit faults.
  Assumes one 40 MHz clock and the unit model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cse_consts.vh"
module test_cpu_stop_error_handler;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [7:0] dec_opcode = 8'h00, op_byte = 8'h00, mem_rdata;
  logic [15:0] dec_ia = 16'h0, dec_oa = 16'h0, fld = 16'h0, xio = 16'h0, mem_addr, resume_ia;
  logic [3:0] nr_cmd = 4'h0, feed_cmd = 4'h0, chk_cmd = 4'h0, mem_lat = 4'h0;
  logic [3:0] unit_not_ready, unit_feed_chk, unit_chk;
  logic dec_valid = 1'b0, start_key = 1'b0, chk_reset_key = 1'b0, sys_reset_key = 1'b0, dbl = 1'b0;
  logic mem_req, mem_ack, run_latch, stop_ind;
  int bad_count = 0, check_count = 0, cyc = 0;
  localparam logic [15:0] FD = 16'h8032;
  localparam logic [15:0] IO0 = 16'h8010;
  always #12.5 hclk = ~hclk;
  cse_stop_error_handler dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dec_valid(dec_valid), .dec_opcode(dec_opcode), .dec_ia(dec_ia),
    .dec_oa_valid(!xio[12]), .dec_oa(dec_oa), .first_register_field(fld[15:12]),
    .second_register_field(fld[11:8]), .first_length_field(fld[7:4]), .second_length_field(fld[3:0]),
    .dec_io(xio[15]), .dec_unit(xio[9:8]), .dec_len(xio[7:0]), .dec_edit_bad(xio[14]),
    .dec_test(xio[13]), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .unit_not_ready(unit_not_ready), .unit_feed_chk(unit_feed_chk),
    .unit_chk(unit_chk), .start_key(start_key), .chk_reset_key(chk_reset_key),
    .sys_reset_key(sys_reset_key), .run_latch(run_latch), .stop_ind(stop_ind), .resume_ia(resume_ia)
  );
  cse_unit_model u_units (
    .hclk(hclk), .hresetn(hresetn), .nr_cmd(nr_cmd), .feed_cmd(feed_cmd), .chk_cmd(chk_cmd),
    .mem_lat(mem_lat), .op_byte(op_byte), .unit_not_ready(unit_not_ready),
    .unit_feed_chk(unit_feed_chk), .unit_chk(unit_chk), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );
  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  // ----------------------------------------
  // bus, keys and decode runs
  // ----------------------------------------
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic hit(input logic sys);
    @(posedge hclk);
    sys_reset_key <= sys;
    chk_reset_key <= !sys;
    repeat (5) @(posedge hclk);
    sys_reset_key <= 1'b0;
    chk_reset_key <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task automatic start_run();
    @(posedge hclk);
    start_key <= 1'b1;
    repeat (5) @(posedge hclk);
    start_key <= 1'b0;
    repeat (3) @(posedge hclk);
    cmp_bit(run_latch, 1'b1);
  endtask
  task automatic run(input logic [7:0] op, input logic [15:0] ia, input logic [15:0] oa,
    input logic [15:0] f, input logic [15:0] x, input logic [7:0] exp);
    int n;
    repeat (8) @(posedge hclk);
    dec_opcode <= op;
    dec_ia <= ia;
    dec_oa <= oa;
    fld <= f;
    xio <= x;
    op_byte <= op;
    dec_valid <= 1'b1;
    @(posedge hclk);
    dec_opcode <= 8'h00;
    dec_valid <= dbl;
    @(posedge hclk);
    dec_valid <= 1'b0;
    n = 0;
    while (run_latch === 1'b1 && n < 60) begin
      @(posedge hclk);
      n = n + 1;
    end
    cmp_bit(run_latch, exp == 8'h00);
    if (exp != 8'h00) begin
      rdchk(`CSE_OFF_HOLD, {16'h0, exp, op});
      rdchk(`CSE_OFF_ADDR, {16'h0, ia});
      rdchk(`CSE_OFF_NEXTIA, {16'h0, ia});
      start_run();
    end
    $display("test op %h at %h done", op, ia);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`CSE_OFF_CTRL, {24'h0, `CSE_CTRL_RST});
    rdchk(`CSE_OFF_MAXLEN, `CSE_MAXLEN_RST);
    rdchk(12'h020, 32'h0);
    ahb(1'b1, `CSE_OFF_HOLD, 32'hffffffff);
    rdchk(`CSE_OFF_HOLD, 32'h0);
    ahb(1'b0, `CSE_OFF_STATUS, 32'h0);
    cmp({30'h0, rd[1:0]}, 32'h2);
    start_run();
    run(8'h00, 16'h0100, 16'h0200, FD, 16'h0, 8'h01);
    run(8'hfa, 16'h0080, 16'h0200, FD, 16'h0, 8'h04);
    run(8'hfa, 16'h0100, 16'h008f, FD, 16'h0, 8'h04);
    run(8'hfa, 16'h0100, 16'h0090, FD, 16'h0, 8'h00);
    run(8'hfa, 16'h0100, 16'h0050, FD, 16'h1000, 8'h00);
    run(8'hfa, 16'h4000, 16'h0200, FD, 16'h0, 8'h05);
    run(8'hfa, 16'h3ffe, 16'h3fff, FD, 16'h0, 8'h00);
    ahb(1'b1, `CSE_OFF_CTRL, 32'hf0);
    run(8'hfa, 16'h1000, 16'h0200, FD, 16'h0, 8'h05);
    run(8'hfa, 16'h0ffe, 16'h1000, FD, 16'h0, 8'h05);
    ahb(1'b1, `CSE_OFF_CTRL, 32'hf1);
    run(8'hfa, 16'h2000, 16'h0200, FD, 16'h0, 8'h05);
    run(8'hfa, 16'h1ffe, 16'h1fff, FD, 16'h0, 8'h00);
    ahb(1'b1, `CSE_OFF_CTRL, 32'h72);
    run(8'hd0, 16'h0100, 16'h0200, FD, 16'h8310, 8'h06);
    ahb(1'b1, `CSE_OFF_CTRL, 32'hf2);
    run(8'hfa, 16'h0101, 16'h0200, FD, 16'h0, 8'h06);
    run(8'h4a, 16'h0100, 16'h0201, FD, 16'h0, 8'h06);
    run(8'h4a, 16'h0100, 16'h0200, FD, 16'h0, 8'h00);
    run(8'h0d, 16'h0100, 16'h0200, 16'h3800, 16'h0, 8'h05);
    run(8'h0d, 16'h0100, 16'h0200, 16'h8300, 16'h0, 8'h00);
    run(8'h07, 16'h0100, 16'h0200, 16'h3300, 16'h0, 8'h00);
    run(8'h47, 16'h0100, 16'h0200, 16'h2000, 16'h0, 8'h00);
    run(8'h18, 16'h0100, 16'h0200, 16'h8300, 16'h0, 8'h05);
    run(8'h4a, 16'h0100, 16'h0200, 16'h2000, 16'h0, 8'h05);
    run(8'h4a, 16'h0100, 16'h0200, 16'h8100, 16'h0, 8'h06);
    run(8'hfa, 16'h0100, 16'h0200, 16'h8823, 16'h0, 8'h06);
    run(8'hfb, 16'h0100, 16'h0200, 16'h8834, 16'h0, 8'h06);
    run(8'hfd, 16'h0100, 16'h0200, 16'h8833, 16'h0, 8'h00);
    run(8'hfc, 16'h0100, 16'h0200, 16'h8898, 16'h0, 8'h06);
    run(8'hfc, 16'h0100, 16'h0200, 16'h8833, 16'h0, 8'h06);
    run(8'hfc, 16'h0100, 16'h0200, 16'h8843, 16'h0, 8'h00);
    mem_lat <= 4'h3;
    run(8'hd0, 16'h0100, 16'h0200, FD, 16'h8000, 8'h06);
    run(8'hd0, 16'h0100, 16'h0200, FD, 16'h8051, 8'h06);
    run(8'hd0, 16'h0100, 16'h0200, FD, 16'h8050, 8'h00);
    run(8'hde, 16'h0100, 16'h0200, FD, 16'h4000, 8'h06);
    run(8'hde, 16'h0100, 16'h0200, FD, 16'h0000, 8'h00);
    nr_cmd <= 4'h2;
    run(8'hd0, 16'h0200, 16'h0300, FD, 16'h8110, 8'hf0);
    nr_cmd <= 4'h0;
    run(8'hd0, 16'h0200, 16'h0300, FD, 16'h8110, 8'h00);
    chk_cmd <= 4'h4;
    run(8'hd0, 16'h0200, 16'h0300, FD, 16'h8210, 8'hf0);
    chk_cmd <= 4'h0;
    run(8'hfa, 16'h0200, 16'h0300, FD, 16'h2200, 8'h00);
    run(8'hd0, 16'h0200, 16'h0300, FD, 16'h8210, 8'h00);
    chk_cmd <= 4'h1;
    run(8'hd0, 16'h0200, 16'h0300, FD, IO0, 8'hf0);
    chk_cmd <= 4'h0;
    hit(1'b0);
    run(8'hd0, 16'h0200, 16'h0300, FD, IO0, 8'h00);
    feed_cmd <= 4'h1;
    run(8'hd0, 16'h0200, 16'h0300, FD, IO0, 8'hf0);
    hit(1'b0);
    run(8'hd0, 16'h0200, 16'h0300, FD, IO0, 8'hf0);
    feed_cmd <= 4'h0;
    run(8'hd0, 16'h0200, 16'h0300, FD, IO0, 8'h00);
    run(8'h00, 16'h0080, 16'h0200, FD, 16'h0, 8'h01);
    dbl <= 1'b1;
    run(8'hfa, 16'h0081, 16'h0200, FD, 16'h0, 8'h04);
    dbl <= 1'b0;
    hit(1'b1);
    rdchk(`CSE_OFF_HOLD, 32'h0);
    rdchk(`CSE_OFF_CTRL, 32'hf2);
    conclude();
  end
endmodule
`default_nettype wire
